/* File: include/ddr_ctl_defs.svh */
// timing counts, field values and reset values of the fast-cycle ddr controller
`ifndef DDR_CTL_DEFS_SVH
`define DDR_CTL_DEFS_SVH
`define CL2_INIT_CYCLES   6'd29
`define CL3_INIT_CYCLES   6'd32
`define MODE_SET_LEAD     6'd2
`define SETTLE_DEFAULT    200
`define BURST_LEN         8'd4
`define WORDS_PER_BURST   8'd2
`define BANK_GAP_CYCLES   3'd2
`define DQS_TAIL_CYCLES   2'd2
`define FULL_WORD_MASK    4'hf
`define HALF_WORD_MASK    4'h3
`define NO_WORD_MASK      4'h0
`endif

/* File: include/ddr_ctl_pkg.sv */
// types shared by the fast-cycle ddr controller files
package ddr_ctl_pkg;
  typedef enum logic [1:0] {
    op_nop     = 2'b00,
    op_read    = 2'b01,
    op_write   = 2'b10,
    op_other   = 2'b11
  } host_op_t;

  typedef enum logic [2:0] {
    cmd_nop               = 3'b000,
    read_branch_cmd       = 3'b001,
    write_branch_cmd      = 3'b010,
    lower_address_cmd     = 3'b011,
    mode_set_cmd          = 3'b100,
    extended_mode_set_cmd = 3'b101,
    refresh_cmd           = 3'b110
  } mem_cmd_t;

  typedef enum logic [3:0] {
    st_init     = 4'h0,
    st_settle   = 4'h1,
    st_idle     = 4'h2,
    st_rda      = 4'h3,
    st_rlal     = 4'h4,
    st_wra      = 4'h5,
    st_wlal     = 4'h6,
    st_conflict = 4'h7,
    st_ref_wra  = 4'h8,
    st_refresh  = 4'h9
  } ctl_state_t;

  typedef struct packed {
    host_op_t    op;
    logic [1:0]  bank;
    logic [14:0] row;
    logic [7:0]  col;
    logic [7:0]  num_xfers;
  } host_req_t;

  typedef struct packed {
    mem_cmd_t    cmd;
    logic [1:0]  bank;
    logic [14:0] addr;
    logic [3:0]  mask;
  } mem_ctl_t;
endpackage

/* File: rtl/read_capture_fifo.sv */
// read words from the link clock domain into the system clock domain
`timescale 1ns/10ps
module read_capture_fifo #(
  parameter int W  = 32,
  parameter int AW = 3
) (
  input  wire logic         link_clk,
  input  wire logic [W-1:0] link_word,
  input  wire logic         link_valid,
  input  wire logic         ref_clk,
  input  wire logic         rst,
  output logic [W-1:0]      word,
  output logic              word_valid
);
  logic [W-1:0] mem [0:(1<<AW)-1];  // storage, written on link clock
  logic         lrst_meta;          // reset synchroniser, first stage
  logic         lrst_r;             // reset in the link domain
  logic [AW:0]  wbin_r;             // write pointer, binary
  logic [AW:0]  wgray_r;            // write pointer, gray
  logic [AW:0]  rbin_r;             // read pointer, binary
  logic [AW:0]  rgray_r;            // read pointer, gray
  logic [AW:0]  rg_meta, rg_sync;   // read pointer seen by writer
  logic [AW:0]  wg_meta, wg_sync;   // write pointer seen by reader
  logic [AW:0]  wbin_nxt;
  logic [AW:0]  rbin_nxt;
  logic         full;
  logic         empty;

  // reset carried into the link domain
  always_ff @(posedge link_clk) begin
    lrst_meta <= rst;
    lrst_r    <= lrst_meta;
  end

  // read pointer crosses into the link domain
  always_ff @(posedge link_clk) begin
    rg_meta <= rgray_r;
    rg_sync <= rg_meta;
  end

  assign wbin_nxt = wbin_r + {{AW{1'b0}}, 1'b1};
  assign full     = (wgray_r == {~rg_sync[AW:AW-1], rg_sync[AW-2:0]});

  // write side: a word arriving while full is lost
  always_ff @(posedge link_clk) begin
    if (lrst_r) begin
      wbin_r  <= '0;
      wgray_r <= '0;
    end else if (link_valid && !full) begin
      mem[wbin_r[AW-1:0]] <= link_word;
      wbin_r  <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
    end
  end

  // write pointer crosses into the system domain
  always_ff @(posedge ref_clk) begin
    wg_meta <= wgray_r;
    wg_sync <= wg_meta;
  end

  assign rbin_nxt = rbin_r + {{AW{1'b0}}, 1'b1};
  assign empty    = (rgray_r == wg_sync);

  // read side: one word per cycle while any is stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rbin_r     <= '0;
      rgray_r    <= '0;
      word       <= '0;
      word_valid <= 1'b0;
    end else begin
      word_valid <= !empty;
      if (!empty) begin
        word    <= mem[rbin_r[AW-1:0]];
        rbin_r  <= rbin_nxt;
        rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      end
    end
  end
endmodule

/* File: rtl/ddr_ctl.sv */
// fast-cycle ddr controller: command sequencing, init, refresh and host data handshakes
// Function
// - done with refresh due or no command: idle
// - idle refresh: write branch, then auto-refresh
// - write: branch plus lower-address pairs until done
// - back-to-back write without conflict skips idle
// - busy bank: conflict path inserts idle cycles
// - reset combines host reset with clock lock
// - init takes 29 or 32 cycles by latency
// - idle accepts command, branches, pulses accept
// - first word with request, then requested words
// - next request no sooner than previous count
// - bank increments on each successive burst
// - bank overflow wraps, column advances by four
// - odd final write burst masks to first two words; read bursts stay unmasked
// - write strobe runs to end of burst
// - one read word per transfer with valid
// - surplus read words dropped, valid deasserted
// - write after read takes the conflict path
// - host data twice the memory data width
`timescale 1ns/10ps
`include "ddr_ctl_defs.svh"
module ddr_ctl
  import ddr_ctl_pkg::*;
#(
  parameter int DQ_W          = 16,
  parameter int SETTLE_CYCLES = `SETTLE_DEFAULT,
  parameter int FIFO_AW       = 3
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              clk_locked,
  input  wire logic              cas_latency,
  input  wire logic [15:0]       refresh_interval,
  input  wire host_req_t         host_req,
  input  wire logic [2*DQ_W-1:0] host_wdata,
  input  wire logic              link_clk,
  input  wire logic [2*DQ_W-1:0] link_rd_word,
  input  wire logic              link_rd_valid,
  output logic                   host_ack_r,
  output logic                   host_data_req_r,
  output logic [2*DQ_W-1:0]      host_rdata_r,
  output logic                   host_rvalid_r,
  output logic                   init_done_r,
  output logic                   host_ready_r,
  output mem_ctl_t               mem_ctl_r,
  output logic [2*DQ_W-1:0]      mem_wdata_r,
  output logic                   mem_wr_en_r,
  output logic                   mem_dqs_en_r
);
  localparam int HW = 2 * DQ_W;  // host word spans two memory beats

  logic             lock_meta;      // lock synchroniser, first stage
  logic             lock_r;         // lock synchronised
  logic             sys_rst;        // combined internal reset
  ctl_state_t       state_r;        // controller state
  ctl_state_t       state_nxt;      // next controller state
  logic             take;           // host request accepted this cycle
  logic             is_rd;          // pending request is a read
  logic             is_wr;          // pending request is a write
  logic             conflict;       // pending request hits the busy bank
  logic             last_burst;     // current burst ends the request
  logic [5:0]       init_len;       // init length by latency
  logic [5:0]       init_cnt_r;     // init cycle counter
  logic [15:0]      settle_cnt_r;   // loop settle countdown
  logic [2:0]       gap_cnt_r;      // conflict idle countdown
  logic [15:0]      ref_cnt_r;      // refresh interval countdown
  logic             refresh_req_r;  // refresh due
  logic [7:0]       xfer_left_r;    // words left in the request
  logic [1:0]       bank_r;         // bank of the next burst
  logic [1:0]       last_bank_r;    // bank of the last burst issued
  logic [14:0]      row_r;          // row of the request
  logic [7:0]       col_r;          // column of the next burst
  logic [7:0]       words_left_r;   // write words still to fetch
  logic [1:0]       dqs_cnt_r;      // strobe tail countdown
  logic [9:0]       rd_expect_r;    // read words still owed to the host
  logic [HW-1:0]    fifo_word;      // word out of the crossing
  logic             fifo_valid;     // word out of the crossing is new

  // clock lock passes two flops before use
  always_ff @(posedge ref_clk) begin
    lock_meta <= clk_locked;
    lock_r    <= lock_meta;
  end
  assign sys_rst = rst | ~lock_r;

  assign is_rd      = (host_req.op == op_read);
  assign is_wr      = (host_req.op == op_write);
  assign conflict   = (host_req.bank == last_bank_r);
  assign last_burst = (xfer_left_r <= `WORDS_PER_BURST);
  assign init_len   = cas_latency ? `CL3_INIT_CYCLES : `CL2_INIT_CYCLES;

  // next state and request acceptance
  always_comb begin
    state_nxt = state_r;
    take      = 1'b0;
    case (state_r)
      st_init: begin
        if (init_cnt_r == init_len - 6'd1) state_nxt = st_settle;
      end
      st_settle: begin
        if (settle_cnt_r == 16'h0000) state_nxt = st_idle;
      end
      st_idle: begin
        if (refresh_req_r) begin
          state_nxt = st_ref_wra;
        end else if (is_rd) begin
          take      = 1'b1;
          state_nxt = st_rda;
        end else if (is_wr) begin
          take      = 1'b1;
          state_nxt = st_wra;
        end
      end
      st_rda: state_nxt = st_rlal;
      st_wra: state_nxt = st_wlal;
      st_rlal: begin
        if (!last_burst) begin
          state_nxt = st_rda;
        end else if (refresh_req_r || !(is_rd || is_wr)) begin
          state_nxt = st_idle;
        end else if (is_rd && !conflict) begin
          take      = 1'b1;
          state_nxt = st_rda;
        end else begin
          state_nxt = st_conflict;
        end
      end
      st_wlal: begin
        if (!last_burst) begin
          state_nxt = st_wra;
        end else if (refresh_req_r || !is_wr) begin
          state_nxt = st_idle;
        end else if (!conflict) begin
          take      = 1'b1;
          state_nxt = st_wra;
        end else begin
          state_nxt = st_conflict;
        end
      end
      st_conflict: begin
        if (gap_cnt_r == 3'd0) state_nxt = st_idle;
      end
      st_ref_wra: state_nxt = st_refresh;
      st_refresh: state_nxt = st_idle;
      default:    state_nxt = st_idle;
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) state_r <= st_init;
    else         state_r <= state_nxt;
  end

  // init and settle counters, readiness flags
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      init_cnt_r   <= 6'h00;
      settle_cnt_r <= 16'h0000;
      init_done_r  <= 1'b0;
      host_ready_r <= 1'b0;
    end else begin
      if (state_r == st_init) init_cnt_r <= init_cnt_r + 6'd1;
      if (state_r == st_init && state_nxt == st_settle) begin
        settle_cnt_r <= SETTLE_CYCLES[15:0];
        init_done_r  <= 1'b1;
      end else if (state_r == st_settle && settle_cnt_r != 16'h0000) begin
        settle_cnt_r <= settle_cnt_r - 16'h0001;
      end
      if (state_r == st_settle && state_nxt == st_idle) host_ready_r <= 1'b1;
    end
  end

  // conflict idle countdown
  always_ff @(posedge ref_clk) begin
    if (sys_rst)                                              gap_cnt_r <= 3'd0;
    else if (state_nxt == st_conflict && state_r != st_conflict) gap_cnt_r <= `BANK_GAP_CYCLES;
    else if (gap_cnt_r != 3'd0)                               gap_cnt_r <= gap_cnt_r - 3'd1;
  end

  // refresh interval counter; a new expiry wins over the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ref_cnt_r     <= 16'h0000;
      refresh_req_r <= 1'b0;
    end else if (state_r == st_init) begin
      ref_cnt_r <= refresh_interval;
    end else if (ref_cnt_r == 16'h0000) begin
      ref_cnt_r     <= refresh_interval;
      refresh_req_r <= 1'b1;
    end else begin
      ref_cnt_r <= ref_cnt_r - 16'h0001;
      if (state_r == st_refresh) refresh_req_r <= 1'b0;
    end
  end

  // request bookkeeping: count, bank and column advance
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      xfer_left_r <= 8'h00;
      bank_r      <= 2'h0;
      last_bank_r <= 2'h3;
      row_r       <= 15'h0000;
      col_r       <= 8'h00;
    end else if (take) begin
      xfer_left_r <= host_req.num_xfers;
      bank_r      <= host_req.bank;
      row_r       <= host_req.row;
      col_r       <= host_req.col;
    end else if (state_r == st_rda || state_r == st_wra) begin
      last_bank_r <= bank_r;  // bank of the branch command now going out
    end else if (state_r == st_rlal || state_r == st_wlal) begin
      xfer_left_r <= last_burst ? 8'h00 : xfer_left_r - `WORDS_PER_BURST;
      bank_r      <= bank_r + 2'd1;
      if (bank_r == 2'h3) col_r <= col_r + `BURST_LEN;
    end
  end

  // accept pulse
  always_ff @(posedge ref_clk) begin
    if (sys_rst) host_ack_r <= 1'b0;
    else         host_ack_r <= take;
  end

  // memory command, address and mask, one cycle behind the state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_ctl_r <= '{cmd: cmd_nop, bank: 2'h0, addr: 15'h0000, mask: `NO_WORD_MASK};
    end else begin
      mem_ctl_r.cmd  <= cmd_nop;
      mem_ctl_r.mask <= `NO_WORD_MASK;
      case (state_r)
        st_init: begin
          if (init_cnt_r == init_len - `MODE_SET_LEAD - 6'd1) mem_ctl_r.cmd <= mode_set_cmd;
          if (init_cnt_r == init_len - 6'd1) mem_ctl_r.cmd <= extended_mode_set_cmd;
        end
        st_rda, st_wra: begin
          mem_ctl_r.cmd  <= (state_r == st_rda) ? read_branch_cmd : write_branch_cmd;
          mem_ctl_r.bank <= bank_r;
          mem_ctl_r.addr <= row_r;
        end
        st_rlal: begin
          mem_ctl_r.cmd  <= lower_address_cmd;
          mem_ctl_r.addr <= {7'h00, col_r};
        end
        st_wlal: begin
          mem_ctl_r.cmd  <= lower_address_cmd;
          mem_ctl_r.addr <= {7'h00, col_r};
          mem_ctl_r.mask <= (xfer_left_r == 8'h01) ? `HALF_WORD_MASK : `FULL_WORD_MASK;
        end
        st_ref_wra: mem_ctl_r.cmd <= write_branch_cmd;
        st_refresh: mem_ctl_r.cmd <= refresh_cmd;
        default:    mem_ctl_r.cmd <= cmd_nop;
      endcase
    end
  end

  // write data: first word with the request, then one per cycle of request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      words_left_r    <= 8'h00;
      host_data_req_r <= 1'b0;
      mem_wdata_r     <= '0;
      mem_wr_en_r     <= 1'b0;
    end else if (take && is_wr) begin
      mem_wdata_r     <= host_wdata;
      mem_wr_en_r     <= 1'b1;
      words_left_r    <= host_req.num_xfers - 8'd1;
      host_data_req_r <= (host_req.num_xfers > 8'd1);
    end else if (host_data_req_r) begin
      mem_wdata_r     <= host_wdata;
      mem_wr_en_r     <= 1'b1;
      words_left_r    <= words_left_r - 8'd1;
      host_data_req_r <= (words_left_r > 8'd1);
    end else begin
      mem_wr_en_r <= 1'b0;
    end
  end

  // strobe stays on through the tail of the burst, masked or not
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dqs_cnt_r    <= 2'd0;
      mem_dqs_en_r <= 1'b0;
    end else begin
      mem_dqs_en_r <= (state_r == st_wlal) || (dqs_cnt_r != 2'd0);
      if (state_r == st_wlal)   dqs_cnt_r <= `DQS_TAIL_CYCLES;
      else if (dqs_cnt_r != 0)  dqs_cnt_r <= dqs_cnt_r - 2'd1;
    end
  end

  // read words cross from the link clock
  read_capture_fifo #(
    .W  (HW),
    .AW (FIFO_AW)
  ) u_capture (
    .link_clk   (link_clk),
    .link_word  (link_rd_word),
    .link_valid (link_rd_valid),
    .ref_clk    (ref_clk),
    .rst        (sys_rst),
    .word       (fifo_word),
    .word_valid (fifo_valid)
  );

  // read return: pass owed words, drop the surplus half burst
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_expect_r   <= 10'h000;
      host_rdata_r  <= '0;
      host_rvalid_r <= 1'b0;
    end else begin
      host_rvalid_r <= fifo_valid && (rd_expect_r != 10'h000);
      if (fifo_valid) host_rdata_r <= fifo_word;
      rd_expect_r <= rd_expect_r
                   + ((take && is_rd) ? {2'b00, host_req.num_xfers} : 10'h000)
                   - ((fifo_valid && rd_expect_r != 10'h000) ? 10'h001 : 10'h000);
    end
  end

  // checks
  sequence s_branch_pair;
    (state_r == st_wra) ##1 (state_r == st_wlal);
  endsequence

  sequence s_refresh_walk;
    (state_r == st_ref_wra) ##1 (state_r == st_refresh) ##1 (state_r == st_idle);
  endsequence

  chk_idle_accept: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == st_idle && !refresh_req_r && is_wr) |=> (host_ack_r && state_r == st_wra))
    else $error("idle write not accepted");

  chk_refresh_walk: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == st_idle && refresh_req_r) |=> s_refresh_walk)
    else $error("refresh sequence broken");

  chk_write_pair: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == st_wra) |-> s_branch_pair ##1 (mem_ctl_r.cmd == lower_address_cmd))
    else $error("write branch not followed by lower address");

  chk_done_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((state_r == st_wlal) && last_burst && refresh_req_r) |=> (state_r == st_idle))
    else $error("refresh due but not idle");

  chk_conflict_path: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((state_r == st_wlal) && last_burst && !refresh_req_r && is_wr && conflict)
      |=> (state_r == st_conflict) [*3] ##1 (state_r == st_idle))
    else $error("conflict idle cycles wrong");

  chk_read_turn: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((state_r == st_rlal) && last_burst && !refresh_req_r && is_wr) |=> (state_r == st_conflict))
    else $error("write after read skipped turnaround");

  chk_odd_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((state_r == st_wlal) && xfer_left_r == 8'h01) |=> (mem_ctl_r.mask == `HALF_WORD_MASK))
    else $error("odd burst mask wrong");

  chk_dqs_tail: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == st_wlal) |=> mem_dqs_en_r [*3])
    else $error("strobe stopped before burst end");

  chk_bank_wrap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ((state_r == st_wlal) && !take && bank_r == 2'h3)
      |=> (bank_r == 2'h0 && col_r == $past(col_r) + `BURST_LEN))
    else $error("bank wrap without column advance");

  chk_init_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mem_ctl_r.cmd == extended_mode_set_cmd) |-> ($past(init_cnt_r) == init_len - 6'd1))
    else $error("init length wrong");

  chk_rvalid_owed: assert property (@(posedge ref_clk) disable iff (sys_rst)
    host_rvalid_r |-> ($past(rd_expect_r) != 10'h000))
    else $error("surplus read word passed");

  chk_ref_expire: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ref_cnt_r == 16'h0000 && state_r != st_init) |=> refresh_req_r)
    else $error("refresh request missing");
endmodule

/* File: dv/mem_model.sv */
// behavioural memory device that answers read bursts on the link clock
`timescale 1ns/10ps
module mem_model
  import ddr_ctl_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire mem_ctl_t mem_ctl_r,
  output logic          link_clk,
  output logic [31:0]   link_rd_word,
  output logic          link_rd_valid
);
  logic [31:0] rq[$];      // words waiting to go back
  logic        rd_br = 0;  // last branch command was a read
  int          n = 0;      // words produced so far
  // free-running recapture clock, phase unrelated to the system clock
  initial begin
    link_clk = 1'b0;
    link_rd_word = 32'h0;
    link_rd_valid = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  // each read lower-address command yields one burst of two words
  always @(posedge ref_clk) begin
    if (mem_ctl_r.cmd === read_branch_cmd) rd_br <= 1'b1;
    if (mem_ctl_r.cmd === write_branch_cmd) rd_br <= 1'b0;
    if (mem_ctl_r.cmd === lower_address_cmd && rd_br) begin
      rq.push_back(32'h5a00_0000 + n);
      rq.push_back(32'h5a00_0001 + n);
      n = n + 2;
    end
  end
  // one word per link cycle; an idle bus shows the inverse of the last word
  always @(posedge link_clk) begin
    link_rd_valid <= rq.size() > 0;
    link_rd_word <= (rq.size() > 0) ? rq.pop_front() : ~link_rd_word;
  end
endmodule

/* File: dv/fast_cycle_ddr_dram_controller_tb.sv */
// self-checking bench of the fast-cycle ddr controller
`timescale 1ns/10ps
module fast_cycle_ddr_dram_controller_tb;
  import ddr_ctl_pkg::*;
  logic        ref_clk = 1'b0;      // system clock
  logic        rst = 1'b1;          // synchronous reset
  logic        clk_locked = 1'b0;   // clock-manager lock
  logic        cas_latency = 1'b0;  // latency select
  host_req_t   host_req = '0;       // host request
  logic [31:0] words[64];           // write words in host order
  logic [5:0]  wr_ptr = '0;         // next free word
  int          dcnt = 0;            // cycles with a data request seen
  logic [5:0]  mon_ptr = '0;        // next word expected at the memory
  logic [31:0] host_wdata;          // offered write word
  logic        link_clk, link_rd_valid, ack, dreq, rvalid, idone, ready, wr_en, dqs_en;
  logic [31:0] link_rd_word, rdata, mem_wdata;
  mem_ctl_t    mem_ctl;             // memory command outputs
  logic [13:0] lq[$];               // bank, column and mask of each lower-address command
  logic        wr_br = 1'b0;        // last branch was a write
  int          tail = 0;            // strobe cycles still owed
  int          rcnt = 0;            // read words seen
  int          rd_next = 0;         // index of the next read word
  int          errors = 0;
  int          total_checks = 0;
  assign host_wdata = words[mon_ptr + 6'(wr_en)];
  always #20 ref_clk = ~ref_clk;
  ddr_ctl #(.SETTLE_CYCLES(4)) ddr_ctl_i (
    .ref_clk(ref_clk), .rst(rst), .clk_locked(clk_locked), .cas_latency(cas_latency),
    .refresh_interval(16'h0400), .host_req(host_req), .host_wdata(host_wdata), .link_clk(link_clk),
    .link_rd_word(link_rd_word), .link_rd_valid(link_rd_valid), .host_ack_r(ack), .host_data_req_r(dreq),
    .host_rdata_r(rdata), .host_rvalid_r(rvalid), .init_done_r(idone), .host_ready_r(ready),
    .mem_ctl_r(mem_ctl), .mem_wdata_r(mem_wdata), .mem_wr_en_r(wr_en), .mem_dqs_en_r(dqs_en));
  mem_model mem_model_i (.ref_clk(ref_clk), .mem_ctl_r(mem_ctl), .link_clk(link_clk),
    .link_rd_word(link_rd_word), .link_rd_valid(link_rd_valid));
  // compares one value and counts it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // prints the counts and the verdict, then stops
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a wait ran out
  task automatic give_up(input string what);
    errors++;
    $display("Error at %0t: timeout %s", $time, what);
    final_report();
  endtask
  // watches memory commands, write words, strobe tail and read words
  always @(posedge ref_clk) begin
    if (mem_ctl.cmd === write_branch_cmd) wr_br <= 1'b1;
    if (mem_ctl.cmd === read_branch_cmd) wr_br <= 1'b0;
    if (dreq === 1'b1) dcnt++;
    if (mem_ctl.cmd === lower_address_cmd) lq.push_back({mem_ctl.bank, mem_ctl.addr[7:0], mem_ctl.mask});
    if (mem_ctl.cmd === lower_address_cmd && wr_br) tail <= 2;
    else if (tail > 0) tail <= tail - 1;
    if ((mem_ctl.cmd === lower_address_cmd && wr_br) || tail > 0) chk(dqs_en, 1, "strobe");
    if (wr_en === 1'b1) begin
      chk(mem_wdata, words[mon_ptr], "write word");
      mon_ptr <= mon_ptr + 6'h1;
    end
    if (rvalid === 1'b1) begin
      chk(rdata, 32'h5a00_0000 + rd_next, "read word");
      rd_next++;
      rcnt++;
    end
  end
  // presents one request from a clock edge and waits for its accept
  task automatic req(input host_op_t op, input logic [1:0] bank, input logic [7:0] col, input logic [7:0] n,
                     input bit rel, output time t);
    int i;
    for (i = 0; i < n && op == op_write; i++) words[wr_ptr + 6'(i)] <= {8'hc3, 8'h0, bank, col, wr_ptr + 6'(i)};
    if (op == op_write) wr_ptr = wr_ptr + n[5:0];
    host_req <= '{op, bank, 15'h0, col, n};
    t = 0;
    for (i = 0; i < 200 && t == 0; i++) begin
      @(posedge ref_clk);
      if (ack === 1'b1) t = $time;
    end
    if (t == 0) give_up("accept");
    if (rel) host_req.op <= op_nop;
  endtask
  // reset with lock low, then timed power-up sequence and settle wait
  task automatic t_init(input logic cl, input int len);
    int i;
    int ms;
    int m;
    rst <= 1'b1;
    clk_locked <= 1'b0;
    cas_latency <= cl;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(mem_ctl.cmd, cmd_nop, "command while unlocked");
    chk(idone, 0, "init while unlocked");
    clk_locked <= 1'b1;
    ms = 0;
    m = 0;
    for (i = 1; i < 80 && m == 0; i++) begin
      @(posedge ref_clk);
      if (mem_ctl.cmd === mode_set_cmd) ms = i;
      if (mem_ctl.cmd === extended_mode_set_cmd) m = i;
    end
    if (m == 0) give_up("power-up");
    chk(32'(m >= len && m <= len + 4), 1, "power-up length");
    chk(32'(m - ms), 2, "mode set lead");
    for (i = 0; i < 40 && ready !== 1'b1; i++) @(posedge ref_clk);
    if (ready !== 1'b1) give_up("ready");
    chk(32'(i >= 4), 1, "settle wait");
  endtask
  // two refreshes: each led by a write branch, spaced by the interval
  task automatic t_refresh();
    int i;
    int hits;
    time ta;
    mem_cmd_t prev;
    hits = 0;
    prev = cmd_nop;
    for (i = 0; i < 2400 && hits < 2; i++) begin
      @(posedge ref_clk);
      if (mem_ctl.cmd === refresh_cmd) begin
        chk(prev, write_branch_cmd, "refresh lead");
        if (hits == 1) chk(32'(($time - ta) / 40 >= 1020 && ($time - ta) / 40 <= 1032), 1, "period");
        ta = $time;
        hits++;
      end
      prev = mem_ctl.cmd;
    end
    if (hits < 2) give_up("refresh");
  endtask
  // one write to each bank, back to back
  task automatic t_bank_writes();
    int b;
    time ta;
    time tb;
    lq.delete();
    @(posedge ref_clk);
    req(op_write, 2'h0, 8'h0, 8'h2, 1'b0, ta);
    for (b = 1; b < 4; b++) begin
      req(op_write, 2'(b), 8'h0, 8'h2, b == 3, tb);
      chk(32'((tb - ta) / 40), 2, "write gap");
      ta = tb;
    end
    repeat (12) @(posedge ref_clk);
    for (b = 0; b < 4; b++) chk(lq[b], {2'(b), 8'h0, 4'hf}, "bank write");
  endtask
  // five words from bank two: bank advance, wrap, column step, half mask
  task automatic t_write5();
    time ta;
    lq.delete();
    dcnt = 0;
    @(posedge ref_clk);
    req(op_write, 2'h2, 8'h0, 8'h5, 1'b1, ta);
    repeat (16) @(posedge ref_clk);
    chk(lq.size(), 3, "burst count");
    chk(dcnt, 4, "data requests");
    chk(lq[0], {2'h2, 8'h0, 4'hf}, "burst 0");
    chk(lq[1], {2'h3, 8'h0, 4'hf}, "burst 1");
    chk(lq[2], {2'h0, 8'h4, 4'h3}, "burst 2");
  endtask
  // same bank twice, and write after read, both pay extra idle cycles
  task automatic t_conflict();
    time ta;
    time tb;
    @(posedge ref_clk);
    req(op_write, 2'h1, 8'h0, 8'h2, 1'b0, ta);
    req(op_write, 2'h1, 8'h10, 8'h2, 1'b1, tb);
    chk(32'((tb - ta) / 40 > 2), 1, "bank conflict gap");
    repeat (10) @(posedge ref_clk);
    req(op_read, 2'h0, 8'h0, 8'h2, 1'b0, ta);
    req(op_write, 2'h1, 8'h0, 8'h2, 1'b1, tb);
    chk(32'((tb - ta) / 40 > 2), 1, "turnaround gap");
    repeat (40) @(posedge ref_clk);
  endtask
  // odd read from bank three, then back-to-back reads
  task automatic t_read();
    time ta;
    time tb;
    lq.delete();
    rcnt = 0;
    @(posedge ref_clk);
    req(op_read, 2'h3, 8'h0, 8'h3, 1'b1, ta);
    repeat (40) @(posedge ref_clk);
    chk(rcnt, 3, "odd read words");
    chk(lq[1], {2'h0, 8'h4, 4'h0}, "read wrap");
    rd_next++;
    rcnt = 0;
    @(posedge ref_clk);
    req(op_read, 2'h0, 8'h0, 8'h2, 1'b0, ta);
    req(op_read, 2'h1, 8'h0, 8'h2, 1'b1, tb);
    chk(32'((tb - ta) / 40), 2, "read gap");
    repeat (40) @(posedge ref_clk);
    chk(rcnt, 4, "paired read words");
  endtask
  // a command that is neither read nor write is never accepted
  task automatic t_other();
    int i;
    logic seen;
    seen = 1'b0;
    @(posedge ref_clk);
    host_req <= '{op_other, 2'h0, 15'h0, 8'h0, 8'h2};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (ack !== 1'b0) seen = 1'b1;
    end
    host_req.op <= op_nop;
    chk(seen, 0, "other command accepted");
  endtask
  initial begin
    t_init(1'b0, 29);
    t_init(1'b1, 32);
    t_refresh();
    t_bank_writes();
    t_write5();
    t_conflict();
    t_read();
    t_other();
    final_report();
  end
endmodule
